// >>> umhp_pkg.sv
// Purpose: Shared constants for the modem handshake pin block
// Assumes: 32-bit AHB-Lite register bus, one register per aligned word
// Notes:   Register data is 8 bits wide, upper bits read as zero
package umhp_pkg;

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] UMHP_OFF_MCR  = 8'h00;
  localparam logic [7:0] UMHP_OFF_MSR  = 8'h04;
  localparam logic [7:0] UMHP_OFF_IER  = 8'h08;
  localparam logic [7:0] UMHP_OFF_ISR  = 8'h0C;
  localparam logic [7:0] UMHP_OFF_ICLR = 8'h10;
  localparam logic [7:0] UMHP_OFF_CFG  = 8'hC0;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int UMHP_MCR_DTR  = 0;
  localparam int UMHP_MCR_RTS  = 1;
  localparam int UMHP_MCR_LOOP = 4;
  localparam int UMHP_IRQ_MS   = 3;
  localparam int UMHP_CFG_PWM  = 2;

  // ****************************************************
  // Reset values and interrupt mask
  // ****************************************************
  localparam logic [7:0] UMHP_MCR_RST  = 8'h00;
  localparam logic [7:0] UMHP_IER_RST  = 8'h00;
  localparam logic [7:0] UMHP_CFG_RST  = 8'h00;
  localparam logic [3:0] UMHP_LVL_RST  = 4'hF;
  localparam logic [7:0] UMHP_IRQ_MASK = 8'h08;

  // ****************************************************
  // Bus slave states
  // ****************************************************
  typedef enum logic [1:0] {
    UMHP_BUS_IDLE = 2'b00,
    UMHP_BUS_ACT  = 2'b01,
    UMHP_BUS_RESP = 2'b11
  } umhp_bus_t;

endpackage

// >>> umhp_top.sv
// Purpose: Modem handshake pins of the second serial port, with PWM pin sharing
// Assumes: tx_busy_in and PWM outputs come from logic on clk_in
// Notes:   Every register access takes one wait state
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module umhp_top
  import umhp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Core and timer side
  input  wire logic        tx_busy_in,
  input  wire logic        pwm1_output_in,
  input  wire logic        pwm2_output_in,
  output logic             irq_out,
  output logic             item_a_out,
  output logic             item_b_out,
  output logic             pwm_gate_out,
  output logic             pwm_clk_out,
  output logic             pwm1_ext_clock_out,
  // Modem pins
  input  wire logic        clear_send_n_in,
  input  wire logic        set_ready_n_in,
  input  wire logic        ring_indicator_n_in,
  input  wire logic        carrier_detect_n_in,
  output logic             terminal_ready_n_out,
  output logic             request_send_n_out,
  // Shared transmit-activity pin
  input  wire logic        tx_active_in,
  output logic             tx_active_out,
  output logic             tx_active_oe_out
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic [4:0]  sync1_ff;
  logic [4:0]  sync2_ff;
  logic [3:0]  prev_ff;
  logic [3:0]  ser_lvl;
  logic [3:0]  chg;
  logic [3:0]  delta_ff;
  logic [7:0]  mcr_ff;
  logic [7:0]  ier_ff;
  logic [7:0]  cfg_ff;
  logic [7:0]  isr_ff;
  logic [7:0]  msr_val;
  logic [7:0]  rd_mux;
  logic [7:0]  addr_ff;
  logic        wr_ff;
  umhp_bus_t   state_ff;
  umhp_bus_t   nxt_state;
  logic        accept;
  logic        msr_rd;
  logic        pwm_mode;
  logic [31:0] hrdata_ff;
  logic        hready_ff;
  logic        irq_ff;
  logic        dtr_n_ff;
  logic        rts_n_ff;
  logic        txa_ff;
  logic        txa_oe_ff;
  logic        gate1_ff;
  logic        gate2_ff;
  logic        gate_ff;
  logic        clk_ff;
  logic        clk1_ff;

  // Register address match
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // ****************************************************
  // Reset release
  // ****************************************************
  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ****************************************************
  // Pin input synchronisers
  // ****************************************************
  // Order: clear-send, set-ready, ring, carrier, tx pin
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= {1'b0, UMHP_LVL_RST};
      sync2_ff <= {1'b0, UMHP_LVL_RST};
    end else begin
      sync1_ff <= {tx_active_in, carrier_detect_n_in, ring_indicator_n_in,
                   set_ready_n_in, clear_send_n_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Serial side sees idle inputs while the pins belong to the timers
  assign pwm_mode = cfg_ff[UMHP_CFG_PWM];
  assign ser_lvl  = pwm_mode ? UMHP_LVL_RST : sync2_ff[3:0];
  assign chg      = ser_lvl ^ prev_ff;

  // ****************************************************
  // Modem status
  // ****************************************************
  // Previous levels for change detection
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= UMHP_LVL_RST;
    end else begin
      prev_ff <= ser_lvl;
    end
  end

  // change flags, set wins over read clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      delta_ff <= 4'h0;
    end else begin
      delta_ff <= (delta_ff & ~{4{msr_rd}}) | chg;
    end
  end

  // carrier in bit 7, flag in bit 3
  // ring in bit 6, flag in bit 2
  assign msr_val = {~ser_lvl[3], ~ser_lvl[2], ~ser_lvl[1], ~ser_lvl[0], delta_ff};

  // ****************************************************
  // Bus slave
  // ****************************************************
  assign accept = hsel_in & htrans_in[1] & hready_in;
  assign msr_rd = (state_ff == UMHP_BUS_ACT) & !wr_ff & reg_hit(addr_ff, UMHP_OFF_MSR);

  // Next bus state
  always_comb begin
    case (state_ff)
      UMHP_BUS_IDLE: nxt_state = accept ? UMHP_BUS_ACT : UMHP_BUS_IDLE;
      UMHP_BUS_ACT:  nxt_state = UMHP_BUS_RESP;
      UMHP_BUS_RESP: nxt_state = accept ? UMHP_BUS_ACT : UMHP_BUS_IDLE;
      default:       nxt_state = UMHP_BUS_IDLE;
    endcase
  end

  // State, captured address phase and ready
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= UMHP_BUS_IDLE;
      addr_ff   <= 8'h00;
      wr_ff     <= 1'b0;
      hready_ff <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      hready_ff <= (nxt_state != UMHP_BUS_ACT);
      if (accept) begin
        addr_ff <= haddr_in[7:0];
        wr_ff   <= hwrite_in;
      end
    end
  end

  // Read data mux, unmapped reads as zero
  always_comb begin
    rd_mux = 8'h00;
    if (reg_hit(addr_ff, UMHP_OFF_MCR)) rd_mux = mcr_ff;
    if (reg_hit(addr_ff, UMHP_OFF_MSR)) rd_mux = msr_val;
    if (reg_hit(addr_ff, UMHP_OFF_IER)) rd_mux = ier_ff;
    if (reg_hit(addr_ff, UMHP_OFF_ISR)) rd_mux = isr_ff;
    if (reg_hit(addr_ff, UMHP_OFF_CFG)) rd_mux = cfg_ff;
  end

  // Read data latched in the wait cycle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (state_ff == UMHP_BUS_ACT && !wr_ff) begin
      hrdata_ff <= {24'h00_0000, rd_mux};
    end
  end

  // Writable registers, applied in the wait cycle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mcr_ff <= UMHP_MCR_RST;
      ier_ff <= UMHP_IER_RST;
      cfg_ff <= UMHP_CFG_RST;
    end else if (state_ff == UMHP_BUS_ACT && wr_ff) begin
      if (reg_hit(addr_ff, UMHP_OFF_MCR)) mcr_ff <= hwdata_in[7:0];
      if (reg_hit(addr_ff, UMHP_OFF_IER)) ier_ff <= hwdata_in[7:0] & UMHP_IRQ_MASK;
      if (reg_hit(addr_ff, UMHP_OFF_CFG)) cfg_ff <= hwdata_in[7:0];
    end
  end

  // ****************************************************
  // Interrupt
  // ****************************************************
  // sticky event bit, set wins over write-one clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      isr_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      if (state_ff == UMHP_BUS_ACT && wr_ff && reg_hit(addr_ff, UMHP_OFF_ICLR)) begin
        isr_ff <= ((isr_ff & ~hwdata_in[7:0]) | {4'h0, |chg, 3'b000}) & UMHP_IRQ_MASK;
      end else begin
        isr_ff <= (isr_ff | {4'h0, |chg, 3'b000}) & UMHP_IRQ_MASK;
      end
      irq_ff <= |(isr_ff & ier_ff);
    end
  end

  // ****************************************************
  // Pin outputs
  // ****************************************************
  // reset leaves both outputs high
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dtr_n_ff <= 1'b1;
      rts_n_ff <= 1'b1;
    end else begin
      // timer outputs take the handshake pins
      // terminal ready from control bit 0
      dtr_n_ff <= pwm_mode ? pwm2_output_in :
                  !(mcr_ff[UMHP_MCR_DTR] & !mcr_ff[UMHP_MCR_LOOP]);
      // request to send from control bit 1
      rts_n_ff <= pwm_mode ? pwm1_output_in :
                  !(mcr_ff[UMHP_MCR_RTS] & !mcr_ff[UMHP_MCR_LOOP]);
    end
  end

  // activity pin follows the transmitter; no clear-send gating
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      txa_ff    <= 1'b0;
      txa_oe_ff <= 1'b1;
    end else begin
      txa_ff    <= !pwm_mode & tx_busy_in;
      txa_oe_ff <= !pwm_mode;
    end
  end

  // input pins routed to the timers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gate1_ff <= 1'b0;
      gate_ff  <= 1'b0;
      clk_ff   <= 1'b0;
      clk1_ff  <= 1'b0;
      gate2_ff <= 1'b0;
    end else begin
      gate1_ff <= pwm_mode & sync2_ff[0];
      gate_ff  <= pwm_mode & sync2_ff[1];
      clk1_ff  <= pwm_mode & sync2_ff[2];
      clk_ff   <= pwm_mode & sync2_ff[3];
      gate2_ff <= pwm_mode & sync2_ff[4];
    end
  end

  assign hrdata_out           = hrdata_ff;
  assign hreadyout_out        = hready_ff;
  assign hresp_out            = 1'b0;
  assign irq_out              = irq_ff;
  assign terminal_ready_n_out = dtr_n_ff;
  assign request_send_n_out   = rts_n_ff;
  assign tx_active_out        = txa_ff;
  assign tx_active_oe_out     = txa_oe_ff;
  assign item_a_out           = gate1_ff;
  assign pwm_gate_out         = gate_ff;
  assign pwm1_ext_clock_out   = clk1_ff;
  assign pwm_clk_out          = clk_ff;
  assign item_b_out           = gate2_ff;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_msr_read;
    (state_ff == UMHP_BUS_ACT) && !wr_ff && (addr_ff == UMHP_OFF_MSR) && (chg == 4'h0);
  endsequence

  sequence s_bus_req;
    hsel_in && htrans_in[1] && hready_in;
  endsequence

  a_dtr_drive: assert property (!pwm_mode && !mcr_ff[UMHP_MCR_LOOP] |=>
    terminal_ready_n_out == !$past(mcr_ff[UMHP_MCR_DTR])) else $error("dtr level wrong");
  a_rts_drive: assert property (!pwm_mode && !mcr_ff[UMHP_MCR_LOOP] |=>
    request_send_n_out == !$past(mcr_ff[UMHP_MCR_RTS])) else $error("rts level wrong");
  a_rts_loop: assert property (!pwm_mode && mcr_ff[UMHP_MCR_LOOP] |=>
    request_send_n_out) else $error("rts active in loopback");
  a_dtr_loop: assert property (!pwm_mode && mcr_ff[UMHP_MCR_LOOP] |=>
    terminal_ready_n_out) else $error("dtr active in loopback");
  a_cts_delta: assert property (chg[0] |=> delta_ff[0] && msr_val[4] == !$past(ser_lvl[0]))
    else $error("cts change lost");
  a_dsr_delta: assert property (chg[1] |=> delta_ff[1] && msr_val[5] == !$past(ser_lvl[1]))
    else $error("dsr change lost");
  a_dcd_delta: assert property (chg[3] |=> delta_ff[3] && msr_val[7] == !$past(ser_lvl[3]))
    else $error("dcd change lost");
  a_ri_delta: assert property (chg[2] |=> delta_ff[2] && msr_val[6] == !$past(ser_lvl[2]))
    else $error("ri change lost");
  a_irq_raise: assert property ((|chg) && ier_ff[UMHP_IRQ_MS] ##1 ier_ff[UMHP_IRQ_MS]
    |=> irq_out) else $error("modem interrupt missing");
  a_tx_active: assert property (!pwm_mode |=> tx_active_out == $past(tx_busy_in))
    else $error("tx activity wrong");
  a_pwm_route: assert property (pwm_mode |=> !tx_active_oe_out &&
    request_send_n_out == $past(pwm1_output_in)) else $error("pwm routing wrong");
  a_read_clear: assert property (s_msr_read |=> delta_ff == 4'h0 &&
    hrdata_ff[3:0] == $past(delta_ff)) else $error("status read did not clear");
  a_bus_wait: assert property (s_bus_req |=> !hreadyout_out ##1 hreadyout_out)
    else $error("bus wait state wrong");

endmodule

// >>> umhp_modem_model.sv
// Purpose: Behavioural modem driving the four handshake inputs
// Assumes: Bench asks for levels, pins move on the next edge
// Notes:   Pins have pull-ups, so they rest high during reset
`timescale 1ns/1ps
module umhp_modem_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Requested levels, bit 0 clear-send up to bit 3 carrier
  input  wire logic [3:0] want_lvl_in,
  // Handshake pins
  output logic            clear_send_n_out,
  output logic            set_ready_n_out,
  output logic            ring_indicator_n_out,
  output logic            carrier_detect_n_out
);
  // ****************
  // Pin drivers
  // ****************
  logic [3:0] pin_ff;

  // Pins follow the request, pulled high in reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_ff <= 4'hF;
    end else begin
      pin_ff <= want_lvl_in;
    end
  end

  // Fan out to the four lines
  assign clear_send_n_out     = pin_ff[0];
  assign set_ready_n_out      = pin_ff[1];
  assign ring_indicator_n_out = pin_ff[2];
  assign carrier_detect_n_out = pin_ff[3];
endmodule

// >>> tb_uart_modem_handshake_pins.sv
// Purpose: Self-checking bench for the modem handshake pin block
// Assumes: One wait state per transfer, modem model on the pins
// Notes:   Random values from a fixed seed, corner cases first
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_uart_modem_handshake_pins
  import umhp_pkg::*;
  ;
  logic        clk_in, rst_b_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic        tx_busy_in, pwm1_output_in, pwm2_output_in, irq_out, tx_drv, tx_pin;
  logic        item_a_out, item_b_out, pwm_gate_out, pwm_clk_out, pwm1_ext_clock_out;
  logic        clear_send_n_in, set_ready_n_in, ring_indicator_n_in, carrier_detect_n_in;
  logic        terminal_ready_n_out, request_send_n_out, tx_active_out, tx_active_oe_out;
  logic [3:0]  want_lvl, cur;
  logic [7:0]  v;
  int          num_errors, num_checks, seed;

  // ****************
  // Design and modem
  // ****************
  umhp_top umhp_top_i (
    .clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
    .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .tx_busy_in,
    .pwm1_output_in, .pwm2_output_in, .irq_out, .item_a_out, .item_b_out, .pwm_gate_out,
    .pwm_clk_out, .pwm1_ext_clock_out, .clear_send_n_in, .set_ready_n_in,
    .ring_indicator_n_in, .carrier_detect_n_in, .terminal_ready_n_out, .request_send_n_out,
    .tx_active_in(tx_pin), .tx_active_out, .tx_active_oe_out
  );
  umhp_modem_model umhp_modem_model_i (
    .clk_in, .rst_b_in, .want_lvl_in(want_lvl), .clear_send_n_out(clear_send_n_in),
    .set_ready_n_out(set_ready_n_in), .ring_indicator_n_out(ring_indicator_n_in),
    .carrier_detect_n_out(carrier_detect_n_in)
  );
  // Shared pin: bench drives it once the block lets go
  assign tx_pin = tx_active_oe_out ? tx_active_out : tx_drv;

  // ****************
  // Helpers
  // ****************
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic done(input string s);
    $display("test %s ended, checks so far %0d", s, num_checks);
  endtask
  // Bounded wait for hready sampled high
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 50);
    if (hreadyout_out !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  // Single word transfer, read data left in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h00_0000, a};
    htrans_in <= 2'b10;
    hwrite_in <= w;
    wait_ready();
    htrans_in <= 2'b00;
    hsel_in   <= 1'b0;
    hwdata_in <= {24'h00_0000, d};
    wait_ready();
    rd = hrdata_out;
  endtask
  // Expected status: inverted levels over change flags
  function automatic logic [7:0] msr_exp(logic [3:0] lvl, logic [3:0] old);
    return {~lvl, lvl ^ old};
  endfunction
  // Expected control pin: active low, loopback forces high
  function automatic logic ctl_pin(logic [7:0] m, int b);
    return ~(m[b] & ~m[UMHP_MCR_LOOP]);
  endfunction

  // ****************
  // Clock and sequence
  // ****************
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    seed = 32'h1135;
    {num_errors, num_checks} = '0;
    {rst_b_in, hsel_in, haddr_in, htrans_in, hwrite_in, hwdata_in} = '0;
    {tx_busy_in, pwm1_output_in, pwm2_output_in, tx_drv} = '0;
    hsize_in = 3'b010;
    want_lvl = 4'hF;
    cur = 4'hF;
    tick(6);
    rst_b_in <= 1'b1;
    tick(6);
    `CHK({request_send_n_out, terminal_ready_n_out}, 2'b11) // inactive
    `CHK({irq_out, tx_active_out, hresp_out}, 3'b000) // quiet
    done("reset");
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h03 : (i == 1) ? 8'h13 : 8'($random(seed)) & 8'h13;
      bus(UMHP_OFF_MCR, 1'b1, v);
      tick(2);
      `CHK(terminal_ready_n_out, ctl_pin(v, UMHP_MCR_DTR)) // pin
      `CHK(request_send_n_out, ctl_pin(v, UMHP_MCR_RTS)) // pin
      bus(UMHP_OFF_MCR, 1'b0, 8'h00);
      `CHK(rd[7:0], v) // readback
    end
    done("control");
    bus(UMHP_OFF_MSR, 1'b0, 8'h00);
    for (int i = 0; i < 12; i++) begin
      want_lvl <= (i < 4) ? cur ^ (4'h1 << i) : 4'($random(seed));
      tick(8);
      bus(UMHP_OFF_MSR, 1'b0, 8'h00);
      `CHK(rd[7:0], msr_exp(want_lvl, cur)) // status
      bus(UMHP_OFF_MSR, 1'b0, 8'h00);
      `CHK(rd[3:0], 4'h0) // flags gone
      cur = want_lvl;
    end
    done("status");
    // raise, clear and mask the modem interrupt
    bus(UMHP_OFF_ICLR, 1'b1, UMHP_IRQ_MASK);
    bus(UMHP_OFF_IER, 1'b1, UMHP_IRQ_MASK);
    cur = cur ^ 4'h1;
    want_lvl <= cur;
    tick(8);
    `CHK(irq_out, 1'b1) // raised
    bus(UMHP_OFF_ICLR, 1'b1, UMHP_IRQ_MASK);
    tick(2);
    `CHK(irq_out, 1'b0) // cleared
    bus(UMHP_OFF_IER, 1'b1, 8'h00);
    cur = cur ^ 4'h8;
    want_lvl <= cur;
    tick(8);
    `CHK(irq_out, 1'b0) // masked
    bus(UMHP_OFF_ISR, 1'b0, 8'h00);
    `CHK(rd, 32'h0000_0008) // sticky
    bus(UMHP_OFF_IER, 1'b1, UMHP_IRQ_MASK);
    tick(2);
    `CHK(irq_out, 1'b1) // unmasked
    bus(UMHP_OFF_ICLR, 1'b1, UMHP_IRQ_MASK);
    bus(UMHP_OFF_IER, 1'b1, 8'h00);
    bus(8'h20, 1'b1, 8'hFF);
    bus(8'h20, 1'b0, 8'h00);
    `CHK(rd, 32'h0000_0000) // unmapped
    done("interrupt");
    // activity pin follows transmitter, clear-send ignored
    for (int i = 0; i < 8; i++) begin
      tx_busy_in <= 1'($random(seed));
      want_lvl <= 4'($random(seed));
      tick(2);
      `CHK({tx_active_out, tx_active_oe_out}, {tx_busy_in, 1'b1}) // follow
    end
    done("activity");
    bus(UMHP_OFF_MCR, 1'b1, 8'h03);
    bus(UMHP_OFF_CFG, 1'b1, 8'h04);
    bus(UMHP_OFF_CFG, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'h04) // readback
    for (int i = 0; i < 8; i++) begin
      {pwm1_output_in, pwm2_output_in, tx_drv} <= 3'($random(seed));
      want_lvl <= 4'($random(seed));
      tick(6);
      `CHK({request_send_n_out, terminal_ready_n_out}, {pwm1_output_in, pwm2_output_in})
      `CHK({pwm_clk_out, pwm1_ext_clock_out, pwm_gate_out, item_a_out}, want_lvl)
      `CHK({item_b_out, tx_active_oe_out, tx_active_out}, {tx_drv, 2'b00})
    end
    bus(UMHP_OFF_CFG, 1'b1, 8'h00);
    tick(2);
    `CHK({request_send_n_out, terminal_ready_n_out}, 2'b00) // back
    done("timer pins");
    conclude();
  end
endmodule
